// File: dv/dap_chk.sv
`timescale 1ns/100ps
module dap_chk #(
   parameter int ROW_W = 15
) (
   input wire logic             CLK_SYS,
   input wire logic             SRST,
   input wire logic             CE,
   input wire logic             CS_N,
   input wire logic             RAS_N,
   input wire logic             CAS_N,
   input wire logic             WE_N,
   input wire logic             CKE,
   input wire logic             A10,
   input wire logic             PSEL,
   input wire logic             PENABLE,
   input wire logic [11:0]      PADDR,
   input wire logic             PREADY,
   input wire logic             PSLVERR,
   input wire logic [7:0]       BANK_OPEN,
   input wire logic [7:0]       BANK_PRECHARGING,
   input wire logic             PD_ACTIVE,
   input wire logic             PD_PRECHARGE,
   input wire logic             DLL_EN,
   input wire logic             INBUF_EN,
   input wire logic [2:0]       REF_BANK,
   input wire logic [ROW_W-1:0] REF_ROW
);
   logic [2:0]       cke_h;
   wire              sel     = CE && !CS_N && CKE && (&cke_h) && !PD_ACTIVE && !PD_PRECHARGE;
   wire              pre_all = sel && !RAS_N && CAS_N && !WE_N && A10;
   wire              refr    = sel && !RAS_N && !CAS_N && WE_N;
   wire [ROW_W+2:0]  refc    = {REF_ROW, REF_BANK};

   always_ff @(posedge CLK_SYS) begin
      cke_h <= {cke_h[1:0], CKE};
   end

   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (SRST);

   rst_clear_a: assert property ($fell(SRST) |-> BANK_OPEN == 8'h00 && refc == '0 && DLL_EN)
      else $error("state not cleared by reset");
   pd_excl_a: assert property (!(PD_ACTIVE && PD_PRECHARGE))
      else $error("both power-down kinds at once");
   ppd_idle_a: assert property ($rose(PD_PRECHARGE) |-> BANK_OPEN == 8'h00)
      else $error("precharge power-down with open bank");
   apd_open_a: assert property ($rose(PD_ACTIVE) |-> BANK_OPEN != 8'h00)
      else $error("active power-down with no open bank");
   dll_off_a: assert property (PD_PRECHARGE |-> !DLL_EN)
      else $error("DLL on in precharge power-down");
   buf_off_a: assert property (INBUF_EN == !(PD_ACTIVE || PD_PRECHARGE))
      else $error("input buffers wrong for power state");
   refc_step_a: assert property ($changed(refc) && !$past(SRST) |-> refc == $past(refc) + 1'b1)
      else $error("refresh counter stepped wrongly");
   ref_count_a: assert property (refr |-> ##[1:4] $changed(refc))
      else $error("refresh did not advance counter");
   pre_all_a: assert property (pre_all |-> ##[1:4] BANK_PRECHARGING == 8'hFF ##1 BANK_OPEN == 8'h00)
      else $error("precharge all missed a bank");
   apb_ready_a: assert property (PSEL && PENABLE && CE |-> PREADY)
      else $error("access cycle not ready");
   apb_err_a: assert property (PSEL && PENABLE && PREADY && PADDR > 12'h00C |-> PSLVERR)
      else $error("unmapped access without error");
endmodule

bind dap_top dap_chk #(.ROW_W(ROW_W)) i_dap_chk (
   .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
   .WE_N(WE_N), .CKE(CKE), .A10(A10), .PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR),
   .PREADY(PREADY), .PSLVERR(PSLVERR), .BANK_OPEN(BANK_OPEN),
   .BANK_PRECHARGING(BANK_PRECHARGING), .PD_ACTIVE(PD_ACTIVE), .PD_PRECHARGE(PD_PRECHARGE),
   .DLL_EN(DLL_EN), .INBUF_EN(INBUF_EN), .REF_BANK(REF_BANK), .REF_ROW(REF_ROW)
);

// File: dv/dap_ctrl_model.sv
`timescale 1ns/100ps
module dap_ctrl_model (
   input  wire logic          clk,
   output dap_pkg::dap_pins_t pins
);
   logic              req_t = 1'b0;
   logic              ack_t = 1'b0;
   logic              cke_r = 1'b0;
   logic              a10_r = 1'b0;
   logic [2:0]        ba_r  = 3'h0;
   logic [2:0]        rcw;
   dap_pkg::dap_cmd_t cmd_r = dap_pkg::CMD_NOP;

   initial pins = 9'h1E0;
   // Row, column and write strobes per command
   assign rcw = (cmd_r == dap_pkg::CMD_ACT) ? 3'h3 : (cmd_r == dap_pkg::CMD_PRE) ? 3'h2 :
                (cmd_r == dap_pkg::CMD_RD) ? 3'h5 : (cmd_r == dap_pkg::CMD_WR) ? 3'h4 :
                (cmd_r == dap_pkg::CMD_REF) ? 3'h1 : 3'h7;

   // Deselect between commands, command, A10 and bank pins toggling
   always @(posedge clk) begin
      pins.cke <= cke_r;
      if (req_t != ack_t) begin
         ack_t <= req_t;
         {pins.cs_n, pins.ras_n, pins.cas_n, pins.we_n} <= {1'b0, rcw};
         {pins.a10, pins.ba} <= {a10_r, ba_r};
      end else begin
         pins.cs_n <= 1'b1;
         {pins.ras_n, pins.cas_n, pins.we_n, pins.a10, pins.ba} <=
            ~{pins.ras_n, pins.cas_n, pins.we_n, pins.a10, pins.ba};
      end
   end

   task automatic issue(input dap_pkg::dap_cmd_t c, input logic [2:0] b, input logic a);
      cmd_r <= c;
      ba_r  <= b;
      a10_r <= a;
      req_t <= ~req_t;
      @(posedge clk);
   endtask

   task automatic set_cke(input logic v);
      cke_r <= v;
      @(posedge clk);
   endtask
endmodule

// File: dv/dap_top_test.sv
`timescale 1ns/100ps
`include "dap_consts.svh"
module dap_top_test;
   logic               clk_sys    = 1'b0;
   logic               srst       = 1'b1;
   logic               ce         = 1'b1;
   logic               psel       = 1'b0;
   logic               penable    = 1'b0;
   logic               pwrite     = 1'b0;
   logic [11:0]        paddr      = 12'h000;
   logic [31:0]        pwdata     = 32'h0000_0000;
   logic [31:0]        prdata;
   logic               pready;
   logic               pslverr;
   logic [7:0]         bk_open;
   logic [7:0]         bk_pre;
   logic [3:0]         pd_st;
   logic [2:0]         ref_bank;
   logic [14:0]        ref_row;
   dap_pkg::dap_pins_t pins;
   int                 bad_count  = 0;
   int                 num_checks = 0;
   int                 cyc        = 0;

   dap_top i_dap_top (
      .CLK_SYS(clk_sys), .SRST(srst), .CE(ce), .CS_N(pins.cs_n), .RAS_N(pins.ras_n),
      .CAS_N(pins.cas_n), .WE_N(pins.we_n), .CKE(pins.cke), .A10(pins.a10), .BA(pins.ba),
      .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
      .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .BANK_OPEN(bk_open),
      .BANK_PRECHARGING(bk_pre), .PD_ACTIVE(pd_st[3]), .PD_PRECHARGE(pd_st[2]),
      .DLL_EN(pd_st[1]), .INBUF_EN(pd_st[0]), .REF_BANK(ref_bank), .REF_ROW(ref_row)
   );
   dap_ctrl_model i_dap_ctrl_model (.clk(clk_sys), .pins(pins));

   always #20 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         finish_test;
      end
   end

   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      r = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask

   task automatic rd(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0000_0000, r, e);
      chk(r, exp);
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic cmd(input dap_pkg::dap_cmd_t c, input int b, input logic a);
      i_dap_ctrl_model.issue(c, 3'(b), a);
   endtask

   // Edges until the bank bit reaches the level
   task automatic wait_bit(ref logic [7:0] v, input int b, input logic lvl, output int n);
      n = 0;
      while (v[b] !== lvl && n < 300) begin
         @(posedge clk_sys);
         n++;
      end
   endtask

   function automatic int ap_delay(logic w, int al, int cl, int bl8, int rtp, int wrc, int left);
      int h = bl8 ? `DAP_HALF_BL8 : `DAP_HALF_BL4;
      int p = al + bl8 * `DAP_PF_BL8 + ((rtp > `DAP_RTP_MIN) ? rtp : `DAP_RTP_MIN);
      int d = w ? al + cl - `DAP_WL_ADJ + h + wrc : ((al + h > p) ? al + h : p);
      return (left > d) ? left : d;
   endfunction

   initial begin
      logic [31:0] r;
      logic [31:0] d;
      logic        e;
      int          n0, n1, k, al, cl, bl8, rtp, tras, trp, wrc, b;
      r = $urandom(95);
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      rd(`DAP_OFF_CFG, `DAP_CFG_RST);
      rd(`DAP_OFF_TIM, `DAP_TIM_RST);
      rd(`DAP_OFF_STAT, 32'h000C_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, r, e);
      chk({r[30:0], e}, 32'h0000_0001);
      wr(`DAP_OFF_REFC, 32'hFFFF_FFFF);
      rd(`DAP_OFF_REFC, 32'h0000_0000);
      d = $urandom;
      wr(`DAP_OFF_CFG, d);
      rd(`DAP_OFF_CFG, d & `DAP_CFG_MASK);
      i_dap_ctrl_model.set_cke(1'b1);
      repeat (4) @(posedge clk_sys);
      for (int i = 0; i < 10; i++) begin
         al   = $urandom_range(3);
         cl   = $urandom_range(5, 3);
         bl8  = $urandom_range(1);
         rtp  = $urandom_range(5, 1);
         tras = $urandom_range(24, 4);
         trp  = $urandom_range(6, 2);
         wrc  = $urandom_range(6, 2);
         b    = $urandom_range(7);
         k    = $urandom_range(5);
         wr(`DAP_OFF_CFG, 32'(al + (cl << 4) + (bl8 << 8) + (wrc << 12)));
         wr(`DAP_OFF_TIM, 32'(tras + (rtp << 8) + (trp << 16)));
         cmd(dap_pkg::CMD_ACT, b, 1'b0);
         wait_bit(bk_open, b, 1'b1, n0);
         repeat (k) @(posedge clk_sys);
         k = tras - (n0 + k + 1);
         cmd(i[0] ? dap_pkg::CMD_WR : dap_pkg::CMD_RD, b, 1'b1);
         wait_bit(bk_open, b, 1'b0, n1);
         chk(32'(n1 - n0), 32'(ap_delay(i[0], al, cl, bl8, rtp, wrc, k)));
         repeat (trp + 8) @(posedge clk_sys);
      end
      wr(`DAP_OFF_TIM, 32'h0004_0310);
      cmd(dap_pkg::CMD_ACT, 5, 1'b0);
      repeat (20) @(posedge clk_sys);
      cmd(dap_pkg::CMD_RD, 5, 1'b0);
      repeat (40) @(posedge clk_sys);
      chk(bk_open, 32'h0000_0020);
      cmd(dap_pkg::CMD_PRE, 5, 1'b0);
      wait_bit(bk_pre, 5, 1'b1, n0);
      wait_bit(bk_pre, 5, 1'b0, n1);
      chk(n1, 32'h0000_0004);
      repeat (2) @(posedge clk_sys);
      cmd(dap_pkg::CMD_PRE, 0, 1'b1);
      wait_bit(bk_pre, 0, 1'b1, n0);
      wait_bit(bk_pre, 0, 1'b0, n1);
      chk(n1, 32'h0000_0005);
      repeat (8) @(posedge clk_sys);
      repeat (9) begin
         cmd(dap_pkg::CMD_REF, $urandom_range(7), 1'($urandom));
         repeat (4) @(posedge clk_sys);
      end
      // Refresh while frozen must be lost
      ce <= 1'b0;
      cmd(dap_pkg::CMD_REF, 0, 1'b0);
      repeat (4) @(posedge clk_sys);
      ce <= 1'b1;
      repeat (4) @(posedge clk_sys);
      chk({ref_row, ref_bank}, 32'h0000_0009);
      rd(`DAP_OFF_REFC, 32'h0000_0009);
      for (int s = 0; s < 3; s++) begin
         wr(`DAP_OFF_CFG, (s == 2) ? 32'h0001_3030 : 32'h0000_3030);
         if (s > 0) cmd(dap_pkg::CMD_ACT, 2, 1'b0);
         repeat (20) @(posedge clk_sys);
         i_dap_ctrl_model.set_cke(1'b0);
         repeat (6) @(posedge clk_sys);
         chk(pd_st, (s == 0) ? 32'h0000_0004 : (s == 1) ? 32'h0000_000A : 32'h0000_0008);
         i_dap_ctrl_model.set_cke(1'b1);
         repeat (6) @(posedge clk_sys);
         chk(pd_st, 32'h0000_0003);
         cmd(dap_pkg::CMD_PRE, 2, 1'b0);
         repeat (10) @(posedge clk_sys);
      end
      srst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      srst <= 1'b0;
      @(posedge clk_sys);
      chk({bk_open, ref_bank, pd_st}, 32'h0000_0003);
      finish_test;
   end
endmodule

// File: rtl/dap_bank.sv
`timescale 1ns/100ps
module dap_bank #(
   parameter int CW = 6
) (
   input  wire logic          clk,
   input  wire logic          srst,
   input  wire logic          ce,
   input  wire logic          act,
   input  wire logic          rd,
   input  wire logic          wr,
   input  wire logic          ap,
   input  wire logic          pre,
   input  wire logic          pre_all,
   input  wire logic [CW-1:0] tras,
   input  wire logic [CW-1:0] rd_nom,
   input  wire logic [CW-1:0] rtp_ld,
   input  wire logic [CW-1:0] wr_ld,
   input  wire logic [CW-1:0] trp,
   output logic               open,
   output logic               precharging,
   output logic               ap_pending
);

   logic [CW-1:0] ras_q;
   logic [CW-1:0] rdn_q;
   logic [CW-1:0] rtp_q;
   logic [CW-1:0] wrn_q;
   logic [CW-1:0] rp_q;
   logic          open_q;
   logic          aprd_q;
   logic          apwr_q;

   function automatic logic [CW-1:0] dec(input logic [CW-1:0] v);
      dec = (v == '0) ? v : v - 1'b1;
   endfunction

   // Count runs out at the coming edge
   function automatic logic due(input logic [CW-1:0] v);
      due = (v <= CW'(1'b1));
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Internal precharge start, on the edge where the last count runs out
   wire ras_ok = due(ras_q);
   wire rd_go  = aprd_q && due(rdn_q) && due(rtp_q);
   wire wr_go  = apwr_q && due(wrn_q);
   wire ap_go  = open_q && ras_ok && (rd_go || wr_go);

   assign open        = open_q;
   assign precharging = (rp_q != '0);
   assign ap_pending  = aprd_q | apwr_q;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge clk) begin
      if (srst) begin
         ras_q  <= '0;
         rdn_q  <= '0;
         rtp_q  <= '0;
         wrn_q  <= '0;
         rp_q   <= '0;
         open_q <= 1'b0;
         aprd_q <= 1'b0;
         apwr_q <= 1'b0;
      end else if (ce) begin
         ras_q <= act ? tras : dec(ras_q);
         rdn_q <= rd ? rd_nom : dec(rdn_q);
         rtp_q <= rd ? rtp_ld : dec(rtp_q);
         wrn_q <= wr ? wr_ld : dec(wrn_q);
         if (act) begin
            open_q <= 1'b1;
         end else if (pre || pre_all || ap_go) begin
            open_q <= 1'b0;
         end
         if (rd) begin
            aprd_q <= ap;
         end else if (ap_go) begin
            aprd_q <= 1'b0;
         end
         if (wr) begin
            apwr_q <= ap;
         end else if (ap_go) begin
            apwr_q <= 1'b0;
         end
         if (pre_all) begin
            rp_q <= CW'(trp + 1'b1);
         end else if (pre || ap_go) begin
            rp_q <= trp;
         end else begin
            rp_q <= dec(rp_q);
         end
      end
   end

endmodule

// File: rtl/dap_consts.svh
`ifndef DAP_CONSTS_SVH
`define DAP_CONSTS_SVH

// Register byte offsets
`define DAP_OFF_CFG    12'h000
`define DAP_OFF_TIM    12'h004
`define DAP_OFF_STAT   12'h008
`define DAP_OFF_REFC   12'h00C

// Configuration fields
`define DAP_CFG_AL     2:0
`define DAP_CFG_CL     6:4
`define DAP_CFG_BL8    8
`define DAP_CFG_WR     14:12
`define DAP_CFG_SLOW   16
`define DAP_CFG_MASK   32'h0001_7177
`define DAP_CFG_RST    32'h0000_3030

// Timing fields, in clock cycles
`define DAP_TIM_TRAS   5:0
`define DAP_TIM_TRTP   11:8
`define DAP_TIM_TRP    19:16
`define DAP_TIM_MASK   32'h000F_0F3F
`define DAP_TIM_RST    32'h0005_0312

// Status fields
`define DAP_ST_OPEN    7:0
`define DAP_ST_PRE     15:8
`define DAP_ST_APD     16
`define DAP_ST_PPD     17
`define DAP_ST_DLL     18
`define DAP_ST_BUF     19
`define DAP_ST_APND    31:24

// Burst and prefetch figures, in clocks; bank count
`define DAP_HALF_BL4   2
`define DAP_HALF_BL8   4
`define DAP_PF_BL8     2
`define DAP_RTP_MIN    2
`define DAP_WL_ADJ     1
`define DAP_NBANK      8

`endif

// File: rtl/dap_pkg.sv
package dap_pkg;

   typedef struct packed {
      logic       cs_n;
      logic       ras_n;
      logic       cas_n;
      logic       we_n;
      logic       cke;
      logic       a10;
      logic [2:0] ba;
   } dap_pins_t;

   typedef enum logic [2:0] {
      CMD_NOP,
      CMD_ACT,
      CMD_PRE,
      CMD_RD,
      CMD_WR,
      CMD_REF,
      CMD_MRS
   } dap_cmd_t;

   typedef enum logic [1:0] {
      PD_NONE,
      PD_PRECHG,
      PD_ACTIVE
   } dap_pd_t;

endpackage

// File: rtl/dap_top.sv
`timescale 1ns/100ps
`include "dap_consts.svh"

// How it works
// - A10 low on read or write keeps bank open; high arms automatic precharge.
// - Read with precharge starts internal precharge AL plus BL/2 after command.
// - Automatic precharge waits until the bank's row-active count expires.
// - Automatic precharge waits for read-to-precharge count; row precharge follows.
// - Internal precharge never starts sooner than two clocks after last prefetch.
// - Write with precharge closes bank after burst end plus write recovery.
// - Precharge time counts from latest precharge; all-bank adds one clock.
// - Refresh command decoded; bank and row come from internal counter.
// - CKE low with NOP enters power-down; type depends on open rows.
// - DLL off in precharge or slow active power-down; buffers off in any power-down.
// - CKE high with NOP leaves power-down; controller waits exit latency.
module dap_top #(
   parameter int ROW_W = 15,
   parameter int CW    = 6
) (
   input  wire logic             CLK_SYS,
   input  wire logic             SRST,
   input  wire logic             CE,
   input  wire logic             CS_N,
   input  wire logic             RAS_N,
   input  wire logic             CAS_N,
   input  wire logic             WE_N,
   input  wire logic             CKE,
   input  wire logic             A10,
   input  wire logic [2:0]       BA,
   input  wire logic             PSEL,
   input  wire logic             PENABLE,
   input  wire logic             PWRITE,
   input  wire logic [11:0]      PADDR,
   input  wire logic [31:0]      PWDATA,
   output logic      [31:0]      PRDATA,
   output logic                  PREADY,
   output logic                  PSLVERR,
   output logic      [7:0]       BANK_OPEN,
   output logic      [7:0]       BANK_PRECHARGING,
   output logic                  PD_ACTIVE,
   output logic                  PD_PRECHARGE,
   output logic                  DLL_EN,
   output logic                  INBUF_EN,
   output logic      [2:0]       REF_BANK,
   output logic      [ROW_W-1:0] REF_ROW
);

   dap_pkg::dap_pins_t pins_raw;
   dap_pkg::dap_pins_t sync1_q;
   dap_pkg::dap_pins_t sync2_q;
   logic               cke_prev_q;
   dap_pkg::dap_pd_t   pd_q;
   dap_pkg::dap_pd_t   pd_d;
   logic [31:0]        cfg_q;
   logic [31:0]        tim_q;
   logic [31:0]        prdata_q;
   logic               cap_q;
   logic [ROW_W+2:0]   ref_q;
   logic [31:0]        stat_w;
   logic [31:0]        rd_mux;
   logic               addr_ok;
   logic [7:0]         ap_pend;

   function automatic dap_pkg::dap_cmd_t decode(input dap_pkg::dap_pins_t p);
      decode = dap_pkg::CMD_NOP;
      if (!p.cs_n) begin
         case ({p.ras_n, p.cas_n, p.we_n})
            3'h3:    decode = dap_pkg::CMD_ACT;
            3'h2:    decode = dap_pkg::CMD_PRE;
            3'h5:    decode = dap_pkg::CMD_RD;
            3'h4:    decode = dap_pkg::CMD_WR;
            3'h1:    decode = dap_pkg::CMD_REF;
            3'h0:    decode = dap_pkg::CMD_MRS;
            default: decode = dap_pkg::CMD_NOP;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser
   assign pins_raw = {CS_N, RAS_N, CAS_N, WE_N, CKE, A10, BA};

   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         sync1_q    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         cke: 1'b0, a10: 1'b0, ba: 3'h0};
         sync2_q    <= '{cs_n: 1'b1, ras_n: 1'b1, cas_n: 1'b1, we_n: 1'b1,
                         cke: 1'b0, a10: 1'b0, ba: 3'h0};
         cke_prev_q <= 1'b0;
      end else if (CE) begin
         sync1_q    <= pins_raw;
         sync2_q    <= sync1_q;
         cke_prev_q <= sync2_q.cke;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Command decode
   wire dap_pkg::dap_cmd_t cmd = decode(sync2_q);
   wire is_nop   = (cmd == dap_pkg::CMD_NOP);
   wire cmd_ok   = cke_prev_q && sync2_q.cke && (pd_q == dap_pkg::PD_NONE);
   wire cmd_act  = cmd_ok && (cmd == dap_pkg::CMD_ACT);
   wire cmd_rd   = cmd_ok && (cmd == dap_pkg::CMD_RD);
   wire cmd_wr   = cmd_ok && (cmd == dap_pkg::CMD_WR);
   wire cmd_pre  = cmd_ok && (cmd == dap_pkg::CMD_PRE) && !sync2_q.a10;
   wire cmd_prea = cmd_ok && (cmd == dap_pkg::CMD_PRE) && sync2_q.a10;
   wire cmd_ref  = cmd_ok && (cmd == dap_pkg::CMD_REF);
   wire pd_enter = cke_prev_q && !sync2_q.cke && is_nop;
   wire pd_exit  = !cke_prev_q && sync2_q.cke && is_nop;
   wire any_open = |BANK_OPEN;

   ////////////////////////////////////////////////////////////////////////////
   // Per-bank timer loads, shared by all banks
   wire [2:0]    al_f    = cfg_q[`DAP_CFG_AL];
   wire [2:0]    cl_f    = cfg_q[`DAP_CFG_CL];
   wire [2:0]    wr_f    = cfg_q[`DAP_CFG_WR];
   wire          bl8     = cfg_q[`DAP_CFG_BL8];
   wire [CW-1:0] half_bl = bl8 ? CW'(`DAP_HALF_BL8) : CW'(`DAP_HALF_BL4);
   wire [CW-1:0] pf_off  = bl8 ? CW'(`DAP_PF_BL8) : CW'(0);
   wire [CW-1:0] trtp_c  = CW'(tim_q[`DAP_TIM_TRTP]);
   wire [CW-1:0] rtp_max = (trtp_c < CW'(`DAP_RTP_MIN)) ? CW'(`DAP_RTP_MIN) : trtp_c;
   wire [CW-1:0] wl_c    = CW'(CW'(al_f) + CW'(cl_f) - CW'(`DAP_WL_ADJ));
   wire [CW-1:0] rd_nom  = CW'(CW'(al_f) + half_bl);
   wire [CW-1:0] rtp_ld  = CW'(CW'(al_f) + pf_off + rtp_max);
   wire [CW-1:0] wr_ld   = CW'(wl_c + half_bl + CW'(wr_f));
   wire [CW-1:0] tras_c  = CW'(tim_q[`DAP_TIM_TRAS]);
   wire [CW-1:0] trp_c   = CW'(tim_q[`DAP_TIM_TRP]);

   genvar gi;
   generate
      for (gi = 0; gi < `DAP_NBANK; gi++) begin : g_bank
         wire hit = (sync2_q.ba == 3'(gi));
         dap_bank #(.CW(CW)) u_bank (
            .clk         (CLK_SYS),
            .srst        (SRST),
            .ce          (CE),
            .act         (cmd_act && hit),
            .rd          (cmd_rd && hit),
            .wr          (cmd_wr && hit),
            .ap          (sync2_q.a10),
            .pre         (cmd_pre && hit),
            .pre_all     (cmd_prea),
            .tras        (tras_c),
            .rd_nom      (rd_nom),
            .rtp_ld      (rtp_ld),
            .wr_ld       (wr_ld),
            .trp         (trp_c),
            .open        (BANK_OPEN[gi]),
            .precharging (BANK_PRECHARGING[gi]),
            .ap_pending  (ap_pend[gi])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Power-down state
   always_comb begin
      pd_d = pd_q;
      case (pd_q)
         dap_pkg::PD_NONE: begin
            if (pd_enter) begin
               pd_d = any_open ? dap_pkg::PD_ACTIVE : dap_pkg::PD_PRECHG;
            end
         end
         dap_pkg::PD_PRECHG: begin
            if (pd_exit) begin
               pd_d = dap_pkg::PD_NONE;
            end
         end
         dap_pkg::PD_ACTIVE: begin
            if (pd_exit) begin
               pd_d = dap_pkg::PD_NONE;
            end
         end
         default: pd_d = dap_pkg::PD_NONE;
      endcase
   end

   assign PD_ACTIVE    = (pd_q == dap_pkg::PD_ACTIVE);
   assign PD_PRECHARGE = (pd_q == dap_pkg::PD_PRECHG);
   assign DLL_EN       = !(PD_PRECHARGE || (PD_ACTIVE && cfg_q[`DAP_CFG_SLOW]));
   assign INBUF_EN     = (pd_q == dap_pkg::PD_NONE);
   assign REF_BANK     = ref_q[2:0];
   assign REF_ROW      = ref_q[ROW_W+2:3];

   ////////////////////////////////////////////////////////////////////////////
   // Register decode
   wire acc  = PSEL && PENABLE;
   wire wr_e = acc && PWRITE && PREADY;

   always_comb begin
      stat_w                = '0;
      stat_w[`DAP_ST_OPEN]  = BANK_OPEN;
      stat_w[`DAP_ST_PRE]   = BANK_PRECHARGING;
      stat_w[`DAP_ST_APD]   = PD_ACTIVE;
      stat_w[`DAP_ST_PPD]   = PD_PRECHARGE;
      stat_w[`DAP_ST_DLL]   = DLL_EN;
      stat_w[`DAP_ST_BUF]   = INBUF_EN;
      stat_w[`DAP_ST_APND]  = ap_pend;
   end

   always_comb begin
      rd_mux  = '0;
      addr_ok = 1'b1;
      if (PADDR == `DAP_OFF_CFG) begin
         rd_mux = cfg_q;
      end else if (PADDR == `DAP_OFF_TIM) begin
         rd_mux = tim_q;
      end else if (PADDR == `DAP_OFF_STAT) begin
         rd_mux = stat_w;
      end else if (PADDR == `DAP_OFF_REFC) begin
         rd_mux = 32'(ref_q);
      end else begin
         addr_ok = 1'b0;
      end
   end

   assign PREADY  = PENABLE && cap_q && CE;
   assign PSLVERR = acc && PREADY && !addr_ok;
   assign PRDATA  = prdata_q;

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge CLK_SYS) begin
      if (SRST) begin
         pd_q     <= dap_pkg::PD_NONE;
         cfg_q    <= `DAP_CFG_RST;
         tim_q    <= `DAP_TIM_RST;
         prdata_q <= '0;
         cap_q    <= 1'b0;
         ref_q    <= '0;
      end else if (CE) begin
         pd_q     <= pd_d;
         cap_q    <= PSEL && !(PENABLE && cap_q);
         prdata_q <= PSEL ? rd_mux : prdata_q;
         if (wr_e && PADDR == `DAP_OFF_CFG) begin
            cfg_q <= PWDATA & `DAP_CFG_MASK;
         end
         if (wr_e && PADDR == `DAP_OFF_TIM) begin
            tim_q <= PWDATA & `DAP_TIM_MASK;
         end
         if (cmd_ref) begin
            ref_q <= (ROW_W+3)'(ref_q + 1'b1);
         end
      end
   end

endmodule
